// ==== bench/sacc_checker.sv ====
// port assertions for the convert control
`default_nettype none
module sacc_checker #(parameter int SETTLE_CYC = 2) (
  input wire logic clk, resetn, convert, dataEnableN, bipolarSel, bipolarOffsetOn,
  input wire logic conversion_done_n, dataOeN,
  input wire logic [7:0] dacCode, dataOut
);
  timeunit 1ns / 1ps;
  localparam int D1 = 8 * SETTLE_CYC, D2 = D1 + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_fall; $fell(convert); endsequence
  a_rise_done: assert property ($rose(convert) |=> conversion_done_n) else $error("done");
  a_rise_clear: assert property ($rose(convert) |=> !dataOut) else $error("clear");
  a_armed_idle: assert property (convert |=> !dacCode) else $error("idle");
  a_msb_first: assert property (s_fall |=> ##1 dacCode == 8'h80) else $error("msb");
  a_done_time: assert property (
    s_fall |=> conversion_done_n [*8] ##[D1:D2] !conversion_done_n) else $error("late");
  a_hold_result: assert property (
    !conversion_done_n && !convert |=> $stable(dataOut)) else $error("hold");
  a_oe_follow: assert property (
    $changed(dataEnableN) |=> dataOeN == $past(dataEnableN)) else $error("enable");
  a_offset_sw: assert property (
    $changed(bipolarSel) |=> bipolarOffsetOn == $past(bipolarSel)) else $error("offset");
endmodule : sacc_checker
bind sacc_convert_control sacc_checker #(.SETTLE_CYC(SETTLE_CYC)) sacc_checker_i (
  .clk(clk), .resetn(resetn), .convert(convert), .dataEnableN(dataEnableN),
  .bipolarSel(bipolarSel), .bipolarOffsetOn(bipolarOffsetOn),
  .conversion_done_n(conversion_done_n), .dataOeN(dataOeN),
  .dacCode(dacCode), .dataOut(dataOut)
);
`default_nettype wire

// ==== bench/sacc_convert_control_tb_top.sv ====
// convert control bench
`default_nettype none
module sacc_convert_control_tb_top;
  timeunit 1ns / 1ps;
  logic clk = 0, resetn = 0, convert = 0, dataEnableN = 1, bipolarSel = 0;
  logic dacAboveInput, bipolarOffsetOn, conversion_done_n, dataOeN;
  logic [7:0] dacCode, dataOut, vin = 0;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  sacc_convert_control #(.SETTLE_CYC(2)) sacc_convert_control_i (
    .clk(clk), .resetn(resetn), .convert(convert), .dataEnableN(dataEnableN),
    .bipolarSel(bipolarSel), .dacAboveInput(dacAboveInput), .dacCode(dacCode),
    .bipolarOffsetOn(bipolarOffsetOn), .conversion_done_n(conversion_done_n),
    .dataOut(dataOut), .dataOeN(dataOeN)
  );
  sacc_input_model sacc_input_model_i (
    .dacCode(dacCode), .vin(vin), .bipolarOffsetOn(bipolarOffsetOn),
    .dacAboveInput(dacAboveInput)
  );
  task automatic conv(input logic [7:0] v, e);
    vin = v;
    convert = 1;
    repeat (100) @(posedge clk);
    #1 convert = 0;
    repeat (40) if (conversion_done_n === 1'b1) @(posedge clk) #1;
    dataEnableN = 0;
    repeat (2) @(posedge clk);
    total_checks++;
    #1 if ({conversion_done_n, dataOeN, dataOut} !== {2'h0, e}) begin
      n_fail++;
      $display("MISMATCH %0t code %h", $time, dataOut);
    end
    dataEnableN = 1;
    @(posedge clk) #1;
  endtask : conv
  task automatic t_codes;
    conv(8'h5a, 8'h5a);
    bipolarSel = 1;
    conv(8'h80, 8'h00);
    conv(8'h00, 8'h80);
    conv(8'h7f, 8'hff);
    $display("coding end");
  endtask : t_codes
  task automatic complete_run;
    n_fail += (cyc >= 3000);
    $display("%0d checks %0d fails", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clk) if (++cyc == 3000) complete_run();
  initial begin
    repeat (8) @(posedge clk);
    #1 resetn = 1;
    t_codes();
    complete_run();
  end
endmodule : sacc_convert_control_tb_top
`default_nettype wire

// ==== bench/sacc_input_model.sv ====
// comparator model of the analog input
`default_nettype none
module sacc_input_model (
  input wire logic [7:0] dacCode, vin,
  input wire logic bipolarOffsetOn,
  output logic dacAboveInput
);
  timeunit 1ns / 1ps;
  assign dacAboveInput = dacCode > (vin ^ {bipolarOffsetOn, 7'h00});
endmodule : sacc_input_model
`default_nettype wire

// ==== verilog/sacc_convert_control.sv ====
// module: successive-approximation convert control with always-driven result port and registered output enable
`default_nettype none
// Function
// - convert rise resets register, done high fast
// - bit trials begin on convert falling edge
// - trial bits from most to least significant
// - set bit, clear if dac exceeds input
// - done low after all eight bits
// - enable low drives result, else floats; here dataOut is always driven and dataOeN is a registered copy of dataEnableN
// - conversion completes within 30 us
// - unipolar straight binary, bipolar offset binary
// - range input switches bipolar offset in
// - bipolar codes 00, 80, ff at scale points
module sacc_convert_control #(
  parameter int unsigned SETTLE_CYC = sacc_pkg::CONV_TIME_TYP_CYC / sacc_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host control
  input wire logic convert,
  input wire logic dataEnableN,
  input wire logic bipolarSel,
  // comparator: high when dac sum exceeds analog input
  input wire logic dacAboveInput,
  // dac drive and bipolar offset switch
  output logic [sacc_pkg::DATA_W-1:0] dacCode,
  output logic bipolarOffsetOn,
  // status, always-driven result data and output enable
  output logic conversion_done_n,
  output logic [sacc_pkg::DATA_W-1:0] dataOut,
  output logic dataOeN
);
  // ----------------------------------------------------------------
  // settle counter constants
  // ----------------------------------------------------------------
  // settle time per bit, counted down to zero before the comparator is read
  localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYC - 1);
  localparam logic [15:0] SETTLE_ZERO = 16'h0000;
  localparam logic [15:0] SETTLE_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every register of the block lives in this one record
  sacc_pkg::sacc_ctl_s ctl_q;
  sacc_pkg::sacc_ctl_s ctl_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // code with the trial bit withdrawn, for a dac sum that overshoots
  function automatic logic [sacc_pkg::DATA_W-1:0] drop_trial(
    input logic [sacc_pkg::DATA_W-1:0] code,
    input logic [sacc_pkg::DATA_W-1:0] trial
  );
    return code & ~trial;
  endfunction : drop_trial

  // code once the comparator has judged the current trial bit
  function automatic logic [sacc_pkg::DATA_W-1:0] judge_trial(
    input logic [sacc_pkg::DATA_W-1:0] code,
    input logic [sacc_pkg::DATA_W-1:0] trial,
    input logic overshoot
  );
    return overshoot ? drop_trial(code, trial) : code;
  endfunction : judge_trial

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    ctl_d = ctl_q;
    ctl_d.convertPrev = convert;
    unique case (ctl_q.state)
      sacc_pkg::SACC_IDLE: begin
        // result and done stand still until the next convert rise
        ctl_d.state = sacc_pkg::SACC_IDLE;
      end
      sacc_pkg::SACC_ARMED: begin
        // trials wait for the falling edge of the convert pulse
        if (!convert) begin
          ctl_d.trialBit = sacc_pkg::MSB_ONLY;
          ctl_d.state = sacc_pkg::SACC_TRIAL;
        end
      end
      sacc_pkg::SACC_TRIAL: begin
        ctl_d.approx = ctl_q.approx | ctl_q.trialBit;
        ctl_d.settleCnt = SETTLE_LOAD;
        ctl_d.state = sacc_pkg::SACC_SETTLE;
      end
      sacc_pkg::SACC_SETTLE: begin
        if (ctl_q.settleCnt != SETTLE_ZERO) begin
          ctl_d.settleCnt = ctl_q.settleCnt - SETTLE_STEP;
        end else begin
          // comparator is read only at the end of the settle time
          ctl_d.approx = judge_trial(ctl_q.approx, ctl_q.trialBit, dacAboveInput);
          if (ctl_q.trialBit[0]) begin
            ctl_d.result = judge_trial(ctl_q.approx, ctl_q.trialBit, dacAboveInput);
            ctl_d.doneN = 1'b0;
            ctl_d.state = sacc_pkg::SACC_IDLE;
          end else begin
            ctl_d.trialBit = ctl_q.trialBit >> 1;
            ctl_d.state = sacc_pkg::SACC_TRIAL;
          end
        end
      end
    endcase
    // a new convert rise restarts from any state
    if (convert && !ctl_q.convertPrev) begin
      ctl_d.state = sacc_pkg::SACC_ARMED;
      ctl_d.approx = sacc_pkg::RESULT_RST;
      ctl_d.result = sacc_pkg::RESULT_RST;
      ctl_d.doneN = 1'b1;
    end
    // outputs are registered copies so that every pin leaves a flip-flop
    ctl_d.dacCode = ctl_d.approx;
    ctl_d.dataOut = ctl_d.result;
    ctl_d.dataOeN = dataEnableN;
    ctl_d.offsetOn = bipolarSel;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= '{state: sacc_pkg::SACC_IDLE, approx: sacc_pkg::RESULT_RST,
                 trialBit: sacc_pkg::HALF_LSB_NONE, result: sacc_pkg::RESULT_RST,
                 settleCnt: 16'h0000, convertPrev: 1'b0, doneN: 1'b1,
                 dataOut: sacc_pkg::RESULT_RST, dataOeN: 1'b1,
                 dacCode: sacc_pkg::RESULT_RST, offsetOn: 1'b0};
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dacCode = ctl_q.dacCode;
  assign bipolarOffsetOn = ctl_q.offsetOn;
  assign conversion_done_n = ctl_q.doneN;
  assign dataOut = ctl_q.dataOut;
  assign dataOeN = ctl_q.dataOeN;
endmodule : sacc_convert_control
`default_nettype wire

// ==== verilog/sacc_pkg.sv ====
// package: constants and carrier types of the successive-approximation convert control
`default_nettype none
package sacc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CONV_PULSE_MIN_NS = 500;
  localparam int unsigned RESET_DONE_MAX_NS = 1500;
  localparam int unsigned CONV_TIME_TYP_NS = 20000;
  localparam int unsigned CONV_TIME_MAX_NS = 30000;
  // least-time count rounds up, longest-time count rounds down
  localparam int unsigned CONV_PULSE_MIN_CYC =
    (CONV_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESET_DONE_MAX_CYC = (RESET_DONE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CONV_TIME_TYP_CYC = (CONV_TIME_TYP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CONV_TIME_MAX_CYC = (CONV_TIME_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned DATA_W = 8;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic [DATA_W-1:0] MSB_ONLY = 8'h80;
  localparam logic [DATA_W-1:0] HALF_LSB_NONE = 8'h00;

  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_ARMED,
    SACC_TRIAL,
    SACC_SETTLE
  } sacc_state_e;

  typedef struct packed {
    sacc_state_e state;
    logic [DATA_W-1:0] approx;
    logic [DATA_W-1:0] trialBit;
    logic [DATA_W-1:0] result;
    logic [15:0] settleCnt;
    logic convertPrev;
    logic doneN;
    logic [DATA_W-1:0] dataOut;
    logic dataOeN;
    logic [DATA_W-1:0] dacCode;
    logic offsetOn;
  } sacc_ctl_s;

  typedef struct packed {
    logic [DATA_W-1:0] dataOut;
    logic dataOeN;
  } sacc_bus_s;
endpackage : sacc_pkg
`default_nettype wire
